//--- rtl/rprm_defines.svh
// Constants for the radio poll register mapper
`ifndef RPRM_DEFINES_SVH
`define RPRM_DEFINES_SVH

`define RPRM_NUM_DEV 48
`define RPRM_REGS_PER_DEV 16
`define RPRM_NUM_IN 8
`define RPRM_LREG_FIRST 1
`define RPRM_LREG_LAST 768
`define RPRM_IO_IN_LAST 384
`define RPRM_DATA_W 16
`define RPRM_ADDR_W 10
`define RPRM_FIFO_DEPTH 16
`define RPRM_CLK_NS 50
`define RPRM_MS_NS 1000000
`define RPRM_MS_CYC (`RPRM_MS_NS / `RPRM_CLK_NS)
`define RPRM_TMO_DEF_MS 5000
`define RPRM_GAP_DEF_MS 5

`endif

//--- rtl/rprm_pkg.sv
// Types for the radio poll register mapper
package rprm_pkg;

    typedef enum logic [2:0] {
        RPRM_MODE_OFF = 3'h0,
        RPRM_MODE_DEV_IN = 3'h1,
        RPRM_MODE_DEV_IO = 3'h2,
        RPRM_MODE_IO_IN = 3'h3,
        RPRM_MODE_IO_IO = 3'h4
    } rprm_mode_t;

    typedef enum logic [3:0] {
        RPRM_ST_IDLE = 4'h1,
        RPRM_ST_GAP = 4'h2,
        RPRM_ST_REQ = 4'h4,
        RPRM_ST_WAIT = 4'h8
    } rprm_state_t;

endpackage

//--- rtl/rprm_fifo.sv
// Synchronous FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none

module rprm_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic push;
    logic pop;

    assign in_ready_out = (cnt != CW'(DEPTH));
    assign push = in_valid_in && in_ready_out;
    // Refill output stage when empty or being drained
    assign pop = (cnt != '0) && (!out_valid_out || out_ready_in);

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            cnt <= cnt + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
        end else if (pop) begin
            out_valid_out <= 1'b1;
            out_data_out <= mem[rptr];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end

endmodule // rprm_fifo

`default_nettype wire

//--- rtl/rprm_top.sv
// Automatic radio polling engine that fills the local register space
`timescale 1ns/1ps
`default_nettype none
`include "rprm_defines.svh"

// How it works
// - While a polling mode is on the engine keeps polling the radio in a loop, with an idle gap before each message.
// - Polling owns local registers 1 to 768, sixteen for the gateway and each of nodes 1 to 47.
// - In mode off no radio transfer is issued at all.
// - Grouped by device, register r of device d lands at local address d*16+r, 1-8 inputs, 9-16 outputs.
// - The gateway is device 0 and the nodes are devices 1 to 47 in both mappings.
// - Grouped by input/output, register r of device d lands at (r-1)*48+(d+1).
// - Grouped by input/output, addresses 1-384 hold inputs and 385-768 hold outputs.
// - Inputs-only modes read inputs and never write outputs to the radio.
// - Input/output modes write a changed output register to the radio.
// - A transaction with no answer within the timeout is abandoned.
// - An idle gap of the configured length precedes each radio message.
// - After reset the timeout is 5 s and the gap 5 ms.
module rprm_top
    import rprm_pkg::*;
#(
    parameter int MS_CYC = `RPRM_MS_CYC,
    parameter int FIFO_DEPTH = `RPRM_FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic cfg_load_in,
    input wire logic [2:0] cfg_mode_in,
    input wire logic [4:0] cfg_tmo_hh_in,
    input wire logic [5:0] cfg_tmo_mm_in,
    input wire logic [5:0] cfg_tmo_ss_in,
    input wire logic [9:0] cfg_tmo_fff_in,
    input wire logic [4:0] cfg_gap_hh_in,
    input wire logic [5:0] cfg_gap_mm_in,
    input wire logic [5:0] cfg_gap_ss_in,
    input wire logic [9:0] cfg_gap_fff_in,
    output logic radio_req_valid_out,
    input wire logic radio_req_ready_in,
    output logic radio_req_write_out,
    output logic [5:0] radio_req_dev_out,
    output logic [4:0] radio_req_reg_out,
    output logic [15:0] radio_req_data_out,
    input wire logic radio_rsp_valid_in,
    input wire logic [15:0] radio_rsp_data_in,
    input wire logic out_chg_valid_in,
    input wire logic [9:0] out_chg_addr_in,
    input wire logic [15:0] out_chg_data_in,
    output logic out_chg_ready_out,
    output logic lreg_wr_valid_out,
    input wire logic lreg_wr_ready_in,
    output logic [9:0] lreg_wr_addr_out,
    output logic [15:0] lreg_wr_data_out,
    output logic poll_active_out,
    output logic timeout_out
);

    localparam int AW = `RPRM_ADDR_W;
    localparam int DW = `RPRM_DATA_W;

    rprm_mode_t mode;
    rprm_state_t state;
    logic [31:0] tmo_ms;
    logic [31:0] gap_ms;
    logic [31:0] tmr;
    logic [31:0] ms_cnt;
    logic ms_tick;
    logic [5:0] cur_dev;
    logic [2:0] cur_reg;
    logic pend;
    logic [AW-1:0] pend_addr;
    logic [DW-1:0] pend_data;
    logic cfg_seen;
    logic io_mode;
    logic grp_dev;
    logic chg_acc;
    logic chg_is_out;
    logic [AW-1:0] chg_a0;
    logic [5:0] chg_dev;
    logic [4:0] chg_reg;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [AW-1:0] push_addr;
    logic gap_done;
    logic txn_end;
    logic tmo_hit;

    function automatic logic [31:0] to_ms(input logic [4:0] hh, input logic [5:0] mm,
                                          input logic [5:0] ss, input logic [9:0] fff);
        to_ms = ((32'(hh) * 32'd60 + 32'(mm)) * 32'd60 + 32'(ss)) * 32'd1000 + 32'(fff);
    endfunction

    function automatic logic [AW-1:0] lmap(input logic by_dev, input logic [5:0] d, input logic [4:0] r);
        if (by_dev) begin
            lmap = AW'(d) * AW'(`RPRM_REGS_PER_DEV) + AW'(r);
        end else begin
            lmap = (AW'(r) - 1'b1) * AW'(`RPRM_NUM_DEV) + AW'(d) + 1'b1;
        end
    endfunction

    assign io_mode = (mode == RPRM_MODE_DEV_IO) || (mode == RPRM_MODE_IO_IO);
    assign grp_dev = (mode == RPRM_MODE_DEV_IN) || (mode == RPRM_MODE_DEV_IO);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode <= RPRM_MODE_OFF;
            tmo_ms <= 32'(`RPRM_TMO_DEF_MS);
            gap_ms <= 32'(`RPRM_GAP_DEF_MS);
            cfg_seen <= 1'b0;
        end else if (cfg_load_in) begin
            mode <= rprm_mode_t'(cfg_mode_in);
            tmo_ms <= to_ms(cfg_tmo_hh_in, cfg_tmo_mm_in, cfg_tmo_ss_in, cfg_tmo_fff_in);
            gap_ms <= to_ms(cfg_gap_hh_in, cfg_gap_mm_in, cfg_gap_ss_in, cfg_gap_fff_in);
            cfg_seen <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond timer, restarted on every load

    assign ms_tick = (ms_cnt == 32'(MS_CYC - 1));
    assign gap_done = (state == RPRM_ST_GAP) && (tmr == '0) && fifo_in_ready && mode != RPRM_MODE_OFF;
    assign tmo_hit = (state == RPRM_ST_WAIT) && !radio_rsp_valid_in && (tmr == '0);
    assign txn_end = (state == RPRM_ST_WAIT) && (radio_rsp_valid_in || tmr == '0);

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ms_cnt <= '0;
            tmr <= '0;
        end else if ((state == RPRM_ST_IDLE) || txn_end) begin
            ms_cnt <= '0;
            tmr <= gap_ms;
        end else if ((state == RPRM_ST_REQ) && radio_req_ready_in) begin
            ms_cnt <= '0;
            tmr <= tmo_ms;
        end else begin
            ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
            if (ms_tick && tmr != '0) begin
                tmr <= tmr - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Poll sequencer

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= RPRM_ST_IDLE;
        end else begin
            case (state)
                RPRM_ST_IDLE: if (mode != RPRM_MODE_OFF) state <= RPRM_ST_GAP;
                RPRM_ST_GAP: begin
                    if (mode == RPRM_MODE_OFF) state <= RPRM_ST_IDLE;
                    else if (gap_done) state <= RPRM_ST_REQ;
                end
                RPRM_ST_REQ: if (radio_req_ready_in) state <= RPRM_ST_WAIT;
                // loop back through the gap to the next poll
                RPRM_ST_WAIT: if (txn_end) state <= RPRM_ST_GAP;
                default: state <= RPRM_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cur_dev <= '0;
            cur_reg <= '0;
        end else if (txn_end && !radio_req_write_out) begin
            cur_reg <= cur_reg + 1'b1;
            if (cur_reg == 3'(`RPRM_NUM_IN - 1)) begin
                cur_dev <= (cur_dev == 6'(`RPRM_NUM_DEV - 1)) ? '0 : cur_dev + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            radio_req_valid_out <= 1'b0;
            radio_req_write_out <= 1'b0;
            radio_req_dev_out <= '0;
            radio_req_reg_out <= '0;
            radio_req_data_out <= '0;
        end else if (gap_done) begin
            radio_req_valid_out <= 1'b1;
            radio_req_write_out <= pend && io_mode;
            radio_req_dev_out <= (pend && io_mode) ? chg_dev : cur_dev;
            radio_req_reg_out <= (pend && io_mode) ? chg_reg : 5'(cur_reg) + 5'h01;
            radio_req_data_out <= pend_data;
        end else if (radio_req_ready_in) begin
            radio_req_valid_out <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            poll_active_out <= 1'b0;
            timeout_out <= 1'b0;
        end else begin
            poll_active_out <= (mode != RPRM_MODE_OFF);
            timeout_out <= tmo_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Changed outputs waiting to be written

    // Pending slot holds one change; back-pressure until sent
    assign chg_a0 = pend_addr - 1'b1;
    assign chg_dev = grp_dev ? chg_a0[9:4] : 6'(chg_a0 % AW'(`RPRM_NUM_DEV));
    assign chg_reg = grp_dev ? 5'(chg_a0[3:0]) + 5'h01 : 5'(chg_a0 / AW'(`RPRM_NUM_DEV)) + 5'h01;
    assign chg_acc = out_chg_valid_in && out_chg_ready_out;
    // outputs are registers 9-16 of each device when grouped by device, 385-768 when grouped by input/output
    assign chg_is_out = (out_chg_addr_in >= AW'(`RPRM_LREG_FIRST))
        && (out_chg_addr_in <= AW'(`RPRM_LREG_LAST))
        && (grp_dev ? ((out_chg_addr_in - 1'b1) & AW'(8)) != '0
                    : out_chg_addr_in > AW'(`RPRM_IO_IN_LAST));

    // hold changed output for the radio
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend <= 1'b0;
            pend_addr <= '0;
            pend_data <= '0;
            out_chg_ready_out <= 1'b1;
        end else begin
            if (chg_acc && io_mode && chg_is_out) begin
                pend <= 1'b1;
                pend_addr <= out_chg_addr_in;
                pend_data <= out_chg_data_in;
                out_chg_ready_out <= 1'b0;
            end else if (txn_end && radio_req_write_out) begin
                pend <= 1'b0;
                out_chg_ready_out <= 1'b1;
            end else if (!io_mode) begin
                pend <= 1'b0;
                out_chg_ready_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data into the local register space

    assign push_addr = lmap(grp_dev, radio_req_dev_out, radio_req_reg_out);
    assign fifo_in_valid = (state == RPRM_ST_WAIT) && radio_rsp_valid_in && !radio_req_write_out;

    // Room is checked before each request, so an answer never finds it full
    rprm_fifo #(
        .WIDTH(AW + DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in({push_addr, radio_rsp_data_in}),
        .out_valid_out(lreg_wr_valid_out),
        .out_ready_in(lreg_wr_ready_in),
        .out_data_out({lreg_wr_addr_out, lreg_wr_data_out})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence seq_last_read;
        txn_end && !radio_req_write_out && cur_reg == 3'h7 && cur_dev == 6'h2f;
    endsequence

    sequence seq_wait_expire;
        (state == RPRM_ST_WAIT) && tmr == '0 && !radio_rsp_valid_in;
    endsequence

    AST_OFF_QUIET: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (mode == RPRM_MODE_OFF && state == RPRM_ST_IDLE) |=> !radio_req_valid_out)
        else $error("Request issued while polling off");
    AST_HOLD_REQ: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (radio_req_valid_out && !radio_req_ready_in) |=> radio_req_valid_out && $stable(radio_req_dev_out))
        else $error("Request dropped before taken");
    AST_LREG_RANGE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        lreg_wr_valid_out |-> (lreg_wr_addr_out >= 10'h001 && lreg_wr_addr_out <= 10'h300))
        else $error("Local address outside 1-768");
    AST_DEV_MAP: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (fifo_in_valid && grp_dev) |-> push_addr == {radio_req_dev_out, 4'h0} + 10'(radio_req_reg_out))
        else $error("Device grouping address wrong");
    AST_IO_MAP: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (fifo_in_valid && !grp_dev) |-> push_addr == (10'(radio_req_reg_out) - 10'h001) * 10'h030
            + 10'(radio_req_dev_out) + 10'h001)
        else $error("In/out grouping address wrong");
    AST_IO_INPUTS_LOW: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (fifo_in_valid && !grp_dev) |-> push_addr <= 10'h180)
        else $error("Input stored above 384");
    AST_NO_WRITE_IN: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (radio_req_valid_out && (mode == RPRM_MODE_DEV_IN || mode == RPRM_MODE_IO_IN)) |-> !radio_req_write_out)
        else $error("Output written in inputs-only mode");
    AST_WRITE_OUTREG: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (radio_req_valid_out && radio_req_write_out) |-> radio_req_reg_out >= 5'h09)
        else $error("Write aimed at an input register");
    AST_TIMEOUT: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        seq_wait_expire |=> timeout_out && state == RPRM_ST_GAP)
        else $error("Expired transaction not abandoned");
    AST_GAP_IDLE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state == RPRM_ST_GAP && tmr != '0) |=> !radio_req_valid_out)
        else $error("Message sent inside the gap");
    AST_DEFAULTS: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !cfg_seen |-> tmo_ms == 32'd5000 && gap_ms == 32'd5)
        else $error("Default timing wrong");
    AST_WRAP: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        seq_last_read |=> cur_dev == 6'h00 && cur_reg == 3'h0)
        else $error("Poll did not wrap to gateway");

endmodule // rprm_top

`default_nettype wire

//--- dv/rprm_radio_model.sv
// Behavioural radio gateway answering the polling engine
`timescale 1ns/1ps
`default_nettype none

module rprm_radio_model (
    input wire logic clk_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [5:0] req_dev_in,
    input wire logic [4:0] req_reg_in,
    input wire logic [15:0] req_data_in,
    input wire logic mute_in,
    input wire logic [3:0] dly_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_data_out,
    output int reads_out,
    output int writes_out,
    output logic [26:0] last_wr_out
);
    logic [5:0] dev;
    logic [4:0] rg;
    initial begin
        req_ready_out = 1'b0;
        rsp_valid_out = 1'b0;
        rsp_data_out = 16'h0;
        reads_out = 0;
        writes_out = 0;
        last_wr_out = 27'h0;
        forever begin
            @(posedge clk_in iff req_valid_in);
            repeat (dly_in) @(posedge clk_in);
            #5 req_ready_out = 1'b1;
            do @(posedge clk_in); while (!req_valid_in);
            dev = req_dev_in;
            rg = req_reg_in;
            if (req_write_in) begin
                writes_out++;
                last_wr_out = {req_dev_in, req_reg_in, req_data_in};
            end else begin
                reads_out++;
            end
            #5 req_ready_out = 1'b0;
            repeat (dly_in + 1) begin
                @(posedge clk_in);
                #5;
            end
            // Silent when muted, so the engine must give up on its own
            if (!mute_in) begin
                rsp_data_out = {dev, rg, 5'h0a};
                rsp_valid_out = 1'b1;
                @(posedge clk_in);
                #5 rsp_valid_out = 1'b0;
            end
            // Stale data never looks valid
            rsp_data_out = ~rsp_data_out;
        end
    end
endmodule // rprm_radio_model

`default_nettype wire

//--- dv/rprm_top_bench.sv
// Self-checking bench for the radio poll register mapper
`timescale 1ns/1ps
`default_nettype none

module rprm_top_bench;
    import rprm_pkg::*;
    localparam int MS = 4;
    localparam int DEPTH = 16;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic load = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [5:0] tss = 6'h0;
    logic [9:0] tff = 10'h0;
    logic [9:0] gff = 10'h0;
    logic rdy = 1'b1;
    logic chv = 1'b0;
    logic [9:0] cha = 10'h0;
    logic [15:0] chd = 16'h0;
    logic mute = 1'b0;
    logic [3:0] dly = 4'h0;
    logic rv, rr, rw, rsv, ocr, lv, pa, tmo;
    logic [5:0] rdev;
    logic [4:0] rreg;
    logic [15:0] rdat, rsd, ld;
    logic [9:0] la;
    logic [26:0] lw;
    int reads, writes;
    int fails = 0;
    int checks = 0;
    logic [9:0] qa[$];
    logic [15:0] qd[$];
    // Change table: mode, address, expected device (-1 dropped), register
    int cm[11] = '{2, 2, 4, 4, 2, 1, 4, 2, 0, 3, 2};
    int ca[11] = '{25, 16, 385, 768, 8, 25, 384, 769, 25, 400, 0};
    int cd[11] = '{1, 0, 0, 47, -1, -1, -1, -1, -1, -1, -1};
    int cr[11] = '{9, 16, 9, 16, 0, 0, 0, 0, 0, 0, 0};

    always #25 clk = ~clk;

    rprm_top #(.MS_CYC(MS), .FIFO_DEPTH(DEPTH)) DUT (
        .core_clk_in(clk), .rstn_in(rstn), .cfg_load_in(load), .cfg_mode_in(mode),
        .cfg_tmo_hh_in(5'h0), .cfg_tmo_mm_in(6'h0), .cfg_tmo_ss_in(tss), .cfg_tmo_fff_in(tff),
        .cfg_gap_hh_in(5'h0), .cfg_gap_mm_in(6'h0), .cfg_gap_ss_in(6'h0), .cfg_gap_fff_in(gff),
        .radio_req_valid_out(rv), .radio_req_ready_in(rr), .radio_req_write_out(rw),
        .radio_req_dev_out(rdev), .radio_req_reg_out(rreg), .radio_req_data_out(rdat),
        .radio_rsp_valid_in(rsv), .radio_rsp_data_in(rsd), .out_chg_valid_in(chv),
        .out_chg_addr_in(cha), .out_chg_data_in(chd), .out_chg_ready_out(ocr),
        .lreg_wr_valid_out(lv), .lreg_wr_ready_in(rdy), .lreg_wr_addr_out(la),
        .lreg_wr_data_out(ld), .poll_active_out(pa), .timeout_out(tmo));

    rprm_radio_model radio (
        .clk_in(clk), .req_valid_in(rv), .req_write_in(rw), .req_dev_in(rdev),
        .req_reg_in(rreg), .req_data_in(rdat), .mute_in(mute), .dly_in(dly),
        .req_ready_out(rr), .rsp_valid_out(rsv), .rsp_data_out(rsd),
        .reads_out(reads), .writes_out(writes), .last_wr_out(lw));

    always @(posedge clk) begin
        if (lv && rdy) begin
            qa.push_back(la);
            qd.push_back(ld);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic do_reset;
        rstn = 1'b0;
        mute = 1'b0;
        dly = 4'h0;
        rdy = 1'b1;
        chv = 1'b0;
        tick(5);
        qa.delete();
        qd.delete();
        rstn = 1'b1;
        tick(1);
    endtask

    task automatic cfg(input logic [2:0] m, input logic [5:0] ss, input logic [9:0] tf, input logic [9:0] gf);
        mode = m;
        tss = ss;
        tff = tf;
        gff = gf;
        load = 1'b1;
        tick(1);
        load = 1'b0;
        tick(2);
    endtask

    // Waits are bounded so a stuck engine shows up as a short queue
    task automatic collect(input int n);
        for (int k = 0; k < 20000 && qa.size() < n; k++) tick(1);
    endtask

    task automatic check_seq(input logic byio, input int n);
        int d;
        int r;
        cmp_rng("lreg count", n, 100000, qa.size());
        for (int i = 0; i < n; i++) begin
            d = (i / 8) % 48;
            r = i % 8 + 1;
            cmp_val("lreg addr", 32'(byio ? (r - 1) * 48 + d + 1 : d * 16 + r), qa[i]);
            cmp_val("lreg data", {d[5:0], r[4:0], 5'h0a}, qd[i]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_off;
        do_reset;
        cmp_val("idle outputs", 5'h01, {rv, lv, pa, tmo, ocr});
        cfg(3'h0, 6'd0, 10'd5, 10'd0);
        tick(200);
        cmp_rng("radio traffic", 0, 0, reads + writes);
        cmp_val("poll active", 1'b0, pa);
    endtask

    task automatic t_by_dev;
        do_reset;
        rdy = 1'b0;
        cfg(3'h1, 6'd0, 10'd2, 10'd0);
        cmp_val("poll active", 1'b1, pa);
        tick(600);
        cmp_rng("stalled reads", DEPTH, DEPTH + 2, reads);
        cmp_val("lreg valid", 1'b1, lv);
        rdy = 1'b1;
        collect(392);
        check_seq(1'b0, 392);
        cmp_rng("radio writes", 0, 0, writes);
    endtask

    task automatic t_by_io;
        do_reset;
        dly = 4'h3;
        cfg(3'h3, 6'd0, 10'd5, 10'd0);
        collect(392);
        check_seq(1'b1, 392);
        cmp_rng("radio writes", 0, 0, writes);
    endtask

    task automatic t_gap;
        int n;
        do_reset;
        cfg(3'h1, 6'd0, 10'd50, 10'd3);
        // Start from a taken request so a stale answer cannot start the count
        n = 0;
        do begin @(posedge clk); n++; end while (!(rv === 1'b1 && rr === 1'b1) && n < 500);
        n = 0;
        do begin @(posedge clk); n++; end while (rsv !== 1'b1 && n < 500);
        n = 0;
        do begin @(posedge clk); n++; end while (rv !== 1'b1 && n < 500);
        cmp_rng("gap cycles", 3 * MS, 3 * MS + 4, n);
        tick(1);
    endtask

    // Timeout of 1.002 s exercises both the seconds and millisecond fields
    task automatic t_timeout;
        int n;
        do_reset;
        mute = 1'b1;
        cfg(3'h1, 6'd1, 10'd2, 10'd0);
        n = 0;
        do begin @(posedge clk); n++; end while (!(rv === 1'b1 && rr === 1'b1) && n < 500);
        n = 0;
        do begin @(posedge clk); n++; end while (tmo !== 1'b1 && n < 5000);
        cmp_rng("timeout cycles", 1002 * MS, 1002 * MS + 4, n);
        @(posedge clk);
        cmp_val("timeout pulse", 1'b0, tmo);
        cmp_rng("lreg words", 0, 0, qa.size());
        tick(1);
    endtask

    task automatic t_changes;
        int w0;
        for (int i = 0; i < 11; i++) begin
            do_reset;
            cfg(3'(cm[i]), 6'd0, 10'd5, 10'd1);
            tick(10);
            w0 = writes;
            chv = 1'b1;
            cha = 10'(ca[i]);
            chd = 16'h1000 + 16'(i);
            @(posedge clk);
            #5 chv = 1'b0;
            cmp_val("chg ready", cd[i] < 0, ocr);
            tick(80);
            cmp_rng("radio writes", w0 + (cd[i] >= 0), w0 + (cd[i] >= 0), writes);
            cmp_val("chg ready after", 1'b1, ocr);
            if (cd[i] >= 0)
                cmp_val("write target", {6'(cd[i]), 5'(cr[i]), 16'h1000 + 16'(i)}, lw);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        t_reset_off;
        t_by_dev;
        t_by_io;
        t_gap;
        t_timeout;
        t_changes;
        tally_and_finish;
    end

    initial begin
        #(40000 * 50);
        fails++;
        tally_and_finish;
    end
endmodule // rprm_top_bench

`default_nettype wire
